// ===== rtl/cpusr_alu.sv
// combinational alu producing result and condition flags
`timescale 1ns/10ps
module cpusr_alu (
  input  wire logic                  [15:0] i_a,
  input  wire logic                  [15:0] i_b,
  input  wire cpusr_pkg::cpusr_op_t         i_op,
  output logic                       [15:0] o_res,
  output cpusr_pkg::cpusr_flags_t           o_flags
);

  logic [8:0]  sum8;
  logic [4:0]  nib;
  logic [16:0] sum16;

  // byte ops use only the low bytes, word add uses all 16 bits
  always_comb begin
    sum8  = 9'h000;
    nib   = 5'h00;
    sum16 = 17'h00000;
    o_res = 16'h0000;
    o_flags = '0;
    case (i_op)
      // [RULE_06] half carry nibble
      // [RULE_12] carry out bit7
      cpusr_pkg::CPUSR_OP_ADD: begin
        sum8  = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]};
        nib   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
        o_res = {8'h00, sum8[7:0]};
        o_flags.c = sum8[8];
        o_flags.h = nib[4];
        // [RULE_11] signed overflow detect
        o_flags.v = (i_a[7] == i_b[7]) && (sum8[7] != i_a[7]);
      end
      cpusr_pkg::CPUSR_OP_SUB: begin
        sum8  = {1'b0, i_a[7:0]} - {1'b0, i_b[7:0]};
        nib   = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]};
        o_res = {8'h00, sum8[7:0]};
        o_flags.c = sum8[8];
        o_flags.h = nib[4];
        o_flags.v = (i_a[7] != i_b[7]) && (sum8[7] != i_a[7]);
      end
      // [RULE_13] carry takes shifted bit
      cpusr_pkg::CPUSR_OP_SHL: begin
        o_res = {8'h00, i_a[6:0], 1'b0};
        o_flags.c = i_a[7];
      end
      cpusr_pkg::CPUSR_OP_SHR: begin
        o_res = {8'h00, 1'b0, i_a[7:1]};
        o_flags.c = i_a[0];
      end
      cpusr_pkg::CPUSR_OP_ADDW: begin
        sum16 = {1'b0, i_a} + {1'b0, i_b};
        o_res = sum16[15:0];
        o_flags.c = sum16[16];
        o_flags.v = (i_a[15] == i_b[15]) && (sum16[15] != i_a[15]);
      end
      default: begin
        o_res = i_a;
      end
    endcase
    // [RULE_09] msb gives negative
    // [RULE_10] zero result flag
    if (i_op == cpusr_pkg::CPUSR_OP_ADDW) begin
      o_flags.n = o_res[15];
      o_flags.z = (o_res == 16'h0000);
    end else begin
      o_flags.n = o_res[7];
      o_flags.z = (o_res[7:0] == 8'h00);
    end
  end

endmodule

// ===== rtl/cpusr_core.sv
// programmer-visible registers, condition codes and register banks behind apb
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps

// Contract
// [RULE_01] hold a 16-bit program counter pointing at the fetched instruction
// [RULE_02] 16-bit accumulator; byte operations use only its low byte
// [RULE_03] 16-bit temp accumulator is second operand; byte ops use low byte
// [RULE_04] 16-bit index register, extra pointer and stack pointer
// [RULE_05] status word upper byte is bank pointer, lower byte condition codes
// [RULE_06] half carry set on carry or borrow between bits 3 and 4
// [RULE_07] interrupt enable flag permits interrupts when one; reset clears it
// [RULE_08] two-bit level field; only higher priority requests serviced
// [RULE_09] negative flag follows result most significant bit
// [RULE_10] zero flag set for zero result, cleared otherwise
// [RULE_11] overflow flag set on two's complement overflow
// [RULE_12] carry flag set on carry or borrow out of bit 7
// [RULE_13] shifts load carry with the bit shifted out
// [RULE_14] 8-bit general registers, banks of eight, selected by bank pointer
// [RULE_15] usable banks are 4, 8 or 16 by device variant
// [RULE_16] 64-kbyte space, i/o lowest, data area just above
// [RULE_17] program area near top, vectors at its highest addresses
// [RULE_18] bank base address is fixed mapping, eight bytes per bank
module cpusr_core (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [1:0]  i_irq_level,
  input  wire logic        i_irq_req,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq_take,
  output logic      [15:0] o_bank_base
);

  // all module state
  typedef struct packed {
    cpusr_pkg::cpusr_regs_t r;
    logic [1:0]             variant;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   irq_take;
    logic [15:0]            bank_base;
    logic [6:0]             gpr_ptr;
    logic [cpusr_pkg::GPR_DEPTH-1:0][7:0] gpr;
  } cpusr_state_t;

  cpusr_state_t q;
  cpusr_state_t next_q;

  logic [15:0]             alu_res;
  cpusr_pkg::cpusr_flags_t alu_flags;
  cpusr_pkg::cpusr_op_t    op_sel;

  // number of banks allowed by the variant code
  function automatic logic [4:0] bank_limit(input logic [1:0] v);
    case (v)
      2'h0:    bank_limit = 5'h04;
      2'h1:    bank_limit = 5'h08;
      default: bank_limit = 5'h10;
    endcase
  endfunction

  // physical address of the first register of a bank
  function automatic logic [15:0] bank_addr(input logic [7:0] bptr);
    bank_addr = cpusr_pkg::GPR_BASE + {8'h00, bptr[4:0], 3'h0};
  endfunction

  // classify an address into one of the memory areas
  function automatic logic [1:0] area_of(input logic [15:0] a);
    if (a >= cpusr_pkg::VECT_BASE)
      area_of = 2'h3;
    else if (a >= cpusr_pkg::PROG_BASE)
      area_of = 2'h2;
    else if (a >= cpusr_pkg::DATA_BASE)
      area_of = 2'h1;
    else
      area_of = 2'h0;
  endfunction

  // operands are accumulator and temp accumulator
  cpusr_alu u_alu (
    .i_a     (q.r.acc),
    .i_b     (q.r.tmp),
    .i_op    (op_sel),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );

  logic access;
  logic wr;
  assign access = psel && penable && q.pready == 1'b0;
  assign wr     = access && pwrite;
  assign op_sel = (wr && paddr == cpusr_pkg::ADDR_OP && pwdata[2:0] <= 3'h4) ?
                  cpusr_pkg::cpusr_op_t'(pwdata[2:0]) : cpusr_pkg::CPUSR_OP_NONE;

  // next-state logic: bus writes, alu results, interrupt gate
  always_comb begin
    logic [7:0] bptr;
    bptr   = 8'h00;
    next_q = q;
    next_q.pready  = 1'b0;
    next_q.pslverr = 1'b0;
    next_q.prdata  = 32'h0000_0000;
    if (access) begin
      next_q.pready = 1'b1;
      if (pwrite) begin
        case (paddr)
          // [RULE_01] program counter write
          cpusr_pkg::ADDR_PROG: next_q.r.prog = pwdata[15:0];
          // [RULE_02] accumulator write
          cpusr_pkg::ADDR_ACC: next_q.r.acc = pwdata[15:0];
          // [RULE_03] temp accumulator write
          cpusr_pkg::ADDR_TMP: next_q.r.tmp = pwdata[15:0];
          // [RULE_04] pointer register writes
          cpusr_pkg::ADDR_IDX: next_q.r.idx = pwdata[15:0];
          cpusr_pkg::ADDR_EXT: next_q.r.ext = pwdata[15:0];
          cpusr_pkg::ADDR_STK: next_q.r.stk = pwdata[15:0];
          cpusr_pkg::ADDR_PSW: next_q.r.psw = pwdata[15:0];
          cpusr_pkg::ADDR_OP: begin
            // [RULE_02] byte result into low byte
            if (op_sel == cpusr_pkg::CPUSR_OP_ADDW)
              next_q.r.acc = alu_res;
            else if (op_sel != cpusr_pkg::CPUSR_OP_NONE)
              next_q.r.acc = {q.r.acc[15:8], alu_res[7:0]};
            if (op_sel != cpusr_pkg::CPUSR_OP_NONE) begin
              next_q.r.psw[cpusr_pkg::CC_N] = alu_flags.n;
              next_q.r.psw[cpusr_pkg::CC_Z] = alu_flags.z;
              next_q.r.psw[cpusr_pkg::CC_V] = alu_flags.v;
              next_q.r.psw[cpusr_pkg::CC_C] = alu_flags.c;
              // half carry only meaningful for byte arithmetic
              if (op_sel == cpusr_pkg::CPUSR_OP_ADD || op_sel == cpusr_pkg::CPUSR_OP_SUB)
                next_q.r.psw[cpusr_pkg::CC_H] = alu_flags.h;
            end
          end
          // [RULE_15] variant picks bank count
          cpusr_pkg::ADDR_MAP:  next_q.variant = pwdata[1:0];
          cpusr_pkg::ADDR_GPR:  next_q.gpr_ptr = pwdata[6:0];
          default: next_q.pslverr = 1'b1;
        endcase
        // bank register data write through the data window
        if (paddr == cpusr_pkg::ADDR_GPR_DAT) begin
          next_q.pslverr = 1'b0;
          next_q.gpr[q.gpr_ptr] = pwdata[7:0];
        end
      end else begin
        case (paddr)
          cpusr_pkg::ADDR_PROG: next_q.prdata = {16'h0000, q.r.prog};
          cpusr_pkg::ADDR_ACC:  next_q.prdata = {16'h0000, q.r.acc};
          cpusr_pkg::ADDR_TMP:  next_q.prdata = {16'h0000, q.r.tmp};
          cpusr_pkg::ADDR_IDX:  next_q.prdata = {16'h0000, q.r.idx};
          cpusr_pkg::ADDR_EXT:  next_q.prdata = {16'h0000, q.r.ext};
          cpusr_pkg::ADDR_STK:  next_q.prdata = {16'h0000, q.r.stk};
          // [RULE_05] status word halves
          cpusr_pkg::ADDR_PSW:  next_q.prdata = {16'h0000, q.r.psw};
          cpusr_pkg::ADDR_OP:   next_q.prdata = 32'h0000_0000;
          cpusr_pkg::ADDR_BANK: next_q.prdata = {16'h0000, q.bank_base};
          cpusr_pkg::ADDR_IRQ:  next_q.prdata = {31'h0000_0000, q.irq_take};
          cpusr_pkg::ADDR_MAP: begin
            // [RULE_16] area class of counter
            next_q.prdata = {20'h00000, 2'h0, area_of(q.r.prog), 6'h00, q.variant};
          end
          cpusr_pkg::ADDR_GPR:  next_q.prdata = {25'h0000000, q.gpr_ptr};
          default: begin
            if (paddr == cpusr_pkg::ADDR_GPR_DAT)
              next_q.prdata = {24'h000000, q.gpr[q.gpr_ptr]};
            else
              next_q.pslverr = 1'b1;
          end
        endcase
      end
    end
    // [RULE_14] active bank from pointer
    bptr = next_q.r.psw[15:8];
    if ({3'h0, bptr[4:0]} >= {3'h0, bank_limit(next_q.variant)})
      bptr = 8'h00;
    // [RULE_18] eight bytes per bank
    next_q.bank_base = bank_addr(bptr);
    // [RULE_07] enable gates requests
    // [RULE_08] only higher priority levels
    next_q.irq_take = i_irq_req && q.r.psw[cpusr_pkg::CC_I] &&
                      (i_irq_level < {q.r.psw[cpusr_pkg::CC_L1], q.r.psw[cpusr_pkg::CC_L0]});
    // [RULE_17] vector area read-back
    if (access && !pwrite && paddr == cpusr_pkg::ADDR_MAP &&
        area_of(q.r.prog) == 2'h3)
      next_q.prdata[31] = 1'b1;
  end

  // register the state, hold while clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      q <= '0;
      q.r.prog  <= cpusr_pkg::RST_PROG;
      q.r.stk   <= cpusr_pkg::RST_STK;
      // [RULE_07] reset clears enable
      q.r.psw   <= cpusr_pkg::RST_PSW;
      q.variant <= cpusr_pkg::RST_VARIANT;
      q.bank_base <= cpusr_pkg::GPR_BASE;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  assign o_prdata    = q.prdata;
  assign o_pready    = q.pready;
  assign o_pslverr   = q.pslverr;
  assign o_irq_take  = q.irq_take;
  assign o_bank_base = q.bank_base;

endmodule

// ===== rtl/cpusr_pkg.sv
// shared constants, types and register map of the cpu status and register banks block
package cpusr_pkg;

  // apb byte addresses of the programmer-visible registers
  localparam logic [7:0] ADDR_PROG    = 8'h00;
  localparam logic [7:0] ADDR_ACC     = 8'h04;
  localparam logic [7:0] ADDR_TMP     = 8'h08;
  localparam logic [7:0] ADDR_IDX     = 8'h0C;
  localparam logic [7:0] ADDR_EXT     = 8'h10;
  localparam logic [7:0] ADDR_STK     = 8'h14;
  localparam logic [7:0] ADDR_PSW     = 8'h18;
  localparam logic [7:0] ADDR_OP      = 8'h1C;
  localparam logic [7:0] ADDR_BANK    = 8'h20;
  localparam logic [7:0] ADDR_IRQ     = 8'h24;
  localparam logic [7:0] ADDR_MAP     = 8'h28;
  localparam logic [7:0] ADDR_GPR     = 8'h2C;
  localparam logic [7:0] ADDR_GPR_DAT = 8'h30;

  // condition code bit positions
  localparam int CC_H  = 7;
  localparam int CC_I  = 6;
  localparam int CC_L1 = 5;
  localparam int CC_L0 = 4;
  localparam int CC_N  = 3;
  localparam int CC_Z  = 2;
  localparam int CC_V  = 1;
  localparam int CC_C  = 0;

  // reset values
  localparam logic [15:0] RST_PROG = 16'hFFFD;
  localparam logic [15:0] RST_STK = 16'h0000;
  localparam logic [15:0] RST_PSW = 16'h0030;
  localparam logic [1:0]  RST_VARIANT = 2'h2;

  // memory layout of the 64-kbyte space
  localparam logic [15:0] IO_BASE    = 16'h0000;
  localparam logic [15:0] DATA_BASE  = 16'h0080;
  localparam logic [15:0] GPR_BASE   = 16'h0100;
  localparam logic [15:0] PROG_BASE  = 16'h8000;
  localparam logic [15:0] VECT_BASE  = 16'hFFC0;

  // bank geometry
  localparam int REGS_PER_BANK = 8;
  localparam int MAX_BANKS     = 16;
  localparam int GPR_DEPTH     = REGS_PER_BANK * MAX_BANKS;

  // operation codes written through the operation register
  typedef enum logic [2:0] {
    CPUSR_OP_ADD,
    CPUSR_OP_SUB,
    CPUSR_OP_SHL,
    CPUSR_OP_SHR,
    CPUSR_OP_ADDW,
    CPUSR_OP_NONE
  } cpusr_op_t;

  // flag result of the alu
  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpusr_flags_t;

  // dedicated registers
  typedef struct packed {
    logic [15:0] prog;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] idx;
    logic [15:0] ext;
    logic [15:0] stk;
    logic [15:0] psw;
  } cpusr_regs_t;

endpackage

// ===== tb/cpusr_checker.sv
// port-level assertions for the status and register bank core
`timescale 1ns/10ps
module cpusr_checker (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0]  i_irq_level,
  input wire logic        i_irq_req,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_irq_take,
  input wire logic [15:0] o_bank_base
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // bus answer timing
  property p_ans; psel && penable && !o_pready && i_ce |=> o_pready; endproperty
  property p_pulse; o_pready && i_ce |=> !o_pready; endproperty
  property p_err; o_pslverr && !pwrite |-> o_pready && o_prdata == 32'h0; endproperty
  // bank base stays inside the bank area, eight bytes apart
  property p_align; o_bank_base[2:0] == 3'h0 && o_bank_base[15:7] == 9'h002; endproperty
  property p_rst; $rose(i_nrst) |-> o_bank_base == 16'h0100 && !o_irq_take; endproperty
  // interrupt acceptance needs a request of higher priority than the lowest level
  property p_noreq; i_ce && !i_irq_req |=> !o_irq_take; endproperty
  property p_lvl3; i_ce && i_irq_level == 2'h3 |=> !o_irq_take; endproperty
  // a stopped clock enable freezes visible state
  property p_hold; !i_ce |=> $stable(o_bank_base) && $stable(o_irq_take); endproperty

  a_ans: assert property (p_ans) else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error read returned data");
  a_align: assert property (p_align) else $error("bank base out of area");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_noreq: assert property (p_noreq) else $error("take without request");
  a_lvl3: assert property (p_lvl3) else $error("lowest level taken");
  a_hold: assert property (p_hold) else $error("state moved while halted");

  c_err: cover property (o_pslverr);
  c_take: cover property (o_irq_take);
  c_halt: cover property (!i_ce ##1 i_ce);
endmodule

bind cpusr_core cpusr_checker chk_u (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .i_irq_level(i_irq_level),
  .i_irq_req(i_irq_req), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_irq_take(o_irq_take), .o_bank_base(o_bank_base)
);

// ===== tb/cpusr_core_tb.sv
// self-checking bench for the status and register bank core
`timescale 1ns/10ps
module cpusr_core_tb;
  localparam logic [7:0] GPR_DATA = 8'h30;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  i_irq_level = 2'h0;
  logic        i_irq_req = 1'b0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_irq_take;
  logic [15:0] o_bank_base;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  cpusr_core dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .i_irq_level(i_irq_level), .i_irq_req(i_irq_req), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq_take(o_irq_take),
    .o_bank_base(o_bank_base));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  // hang guard, well above the few hundred cycles needed
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, x, g);
    end
  endtask

  // one apb transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // no cycle count assumed; only the hang guard ends a stuck wait
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, x, r);
  endtask

  task automatic t_reset();
    rd("counter", cpusr_pkg::ADDR_PROG, 32'hFFFD);
    rd("psw", cpusr_pkg::ADDR_PSW, 32'h0030);
    rd("bank", cpusr_pkg::ADDR_BANK, 32'h0100);
  endtask

  // sixteen-bit registers keep all bits, upper word reads zero
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      wr(cpusr_pkg::ADDR_PROG + 8'(4 * i), {16'hFFFF, 16'hA357 + 16'(i)});
      rd("reg", cpusr_pkg::ADDR_PROG + 8'(4 * i), {16'h0, 16'hA357 + 16'(i)});
    end
  endtask

  // {op, acc, tmp, result, flag mask, flags}
  task automatic t_alu();
    logic [47:0] t [8] = '{48'h00_08_08_10_8F_80, 48'h00_80_80_00_8F_07,
      48'h00_7F_01_80_8F_8A, 48'h01_00_01_FF_8F_89, 48'h02_81_01_02_01_01,
      48'h03_01_01_00_01_01, 48'h03_02_01_01_01_00, 48'h02_40_01_80_0C_08};
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 8; i++) begin
      wr(cpusr_pkg::ADDR_PSW, 32'h0);
      wr(cpusr_pkg::ADDR_ACC, {24'h0, t[i][39:32]});
      wr(cpusr_pkg::ADDR_TMP, {24'h0, t[i][31:24]});
      wr(cpusr_pkg::ADDR_OP, {24'h0, t[i][47:40]});
      apb(1'b0, cpusr_pkg::ADDR_ACC, 32'h0, r, e);
      chk("result", {24'h0, t[i][23:16]}, {24'h0, r[7:0]});
      apb(1'b0, cpusr_pkg::ADDR_PSW, 32'h0, r, e);
      chk("flags", {24'h0, t[i][7:0]}, {24'h0, r[7:0] & t[i][15:8]});
    end
    // byte add must leave the upper byte alone
    wr(cpusr_pkg::ADDR_ACC, 32'h12FF);
    wr(cpusr_pkg::ADDR_TMP, 32'h0101);
    wr(cpusr_pkg::ADDR_OP, 32'h0);
    rd("byte sum", cpusr_pkg::ADDR_ACC, 32'h1200);
    wr(cpusr_pkg::ADDR_ACC, 32'h12FF);
    wr(cpusr_pkg::ADDR_OP, 32'h4);
    rd("wide sum", cpusr_pkg::ADDR_ACC, 32'h1400);
    // an undefined code leaves the accumulator as it was
    wr(cpusr_pkg::ADDR_OP, 32'h7);
    rd("no op", cpusr_pkg::ADDR_ACC, 32'h1400);
  endtask

  // {variant, bank pointer, base}
  task automatic t_bank();
    logic [27:0] t [8] = '{28'h2_03_0118, 28'h2_0F_0178, 28'h0_0F_0100,
      28'h0_03_0118, 28'h1_07_0138, 28'h1_08_0100, 28'h3_0F_0178, 28'h2_00_0100};
    for (int i = 0; i < 8; i++) begin
      wr(cpusr_pkg::ADDR_MAP, {30'h0, t[i][25:24]});
      wr(cpusr_pkg::ADDR_PSW, {16'h0, t[i][23:16], 8'h00});
      repeat (2) @(posedge i_clk);
      chk("base", {16'h0, t[i][15:0]}, {16'h0, o_bank_base});
      rd("base reg", cpusr_pkg::ADDR_BANK, {16'h0, t[i][15:0]});
    end
    wr(cpusr_pkg::ADDR_GPR, 32'h5);
    wr(GPR_DATA, 32'h1A5);
    rd("gpr", GPR_DATA, 32'hA5);
  endtask

  // {status word, request level, taken}
  task automatic t_irq();
    logic [23:0] t [5] = '{24'h0030_0_0, 24'h0070_0_1, 24'h0070_3_0,
      24'h0050_1_0, 24'h0050_0_1};
    i_irq_req <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(cpusr_pkg::ADDR_PSW, {16'h0, t[i][23:8]});
      i_irq_level <= t[i][5:4];
      repeat (3) @(posedge i_clk);
      chk("take", {31'h0, t[i][0]}, {31'h0, o_irq_take});
      rd("take reg", cpusr_pkg::ADDR_IRQ, {31'h0, t[i][0]});
    end
    i_irq_req <= 1'b0;
  endtask

  // {counter, area}
  task automatic t_map();
    logic [19:0] t [6] = '{20'h007F_0, 20'h0080_1, 20'h7FFF_1, 20'h8000_2,
      20'hFFBF_2, 20'hFFC0_3};
    for (int i = 0; i < 6; i++) begin
      wr(cpusr_pkg::ADDR_PROG, {16'h0, t[i][19:4]});
      rd("area", cpusr_pkg::ADDR_MAP, {t[i][1:0] == 2'h3, 21'h0, t[i][1:0], 8'h02});
    end
  endtask

  task automatic t_err_halt();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, 8'h44, 32'h0, r, e);
    chk("unmapped wr err", 32'h1, {31'h0, e});
    rd("op read", cpusr_pkg::ADDR_OP, 32'h0);
    wr(cpusr_pkg::ADDR_PSW, 32'h0200);
    i_ce <= 1'b0;
    fork
      wr(cpusr_pkg::ADDR_PSW, 32'h0400);
      begin
        repeat (6) @(posedge i_clk);
        chk("halted base", 32'h0110, {16'h0, o_bank_base});
        i_ce <= 1'b1;
      end
    join
    repeat (2) @(posedge i_clk);
    chk("resumed base", 32'h0120, {16'h0, o_bank_base});
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_regs();
    t_alu();
    t_bank();
    t_irq();
    t_map();
    t_err_halt();
    // mid-run reset must clear the enable flag and the bank again
    wr(cpusr_pkg::ADDR_PSW, 32'h03C0);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    finish_test();
  end
endmodule
